// ===== rtl/odc_pkg.sv
package odc_pkg;
  // register byte offsets (block-own map)
  localparam logic [7:0] REG_BYTE = 8'h00;   // write: byte in, bit 8 = data/command select
  localparam logic [7:0] REG_CTRL = 8'h04;   // contrast, page, offset readback
  localparam logic [7:0] REG_MODE = 8'h08;   // mode flags readback
  localparam logic [7:0] REG_STAT = 8'h0C;   // decoder status
  localparam int DC_BIT = 8;                 // data/command select position in REG_BYTE
  // opcodes
  localparam logic [7:0] OP_CONTRAST = 8'h81;
  localparam logic [6:0] OP_ENTIRE = 7'h52;  // 1010010x
  localparam logic [6:0] OP_INVERSE = 7'h53; // 1010011x
  localparam logic [7:0] OP_MUX = 8'hA8;
  localparam logic [6:0] OP_PANEL = 7'h57;   // 1010111x
  localparam logic [3:0] OP_PAGE = 4'hB;     // 1011xxxx
  localparam logic [3:0] OP_SCAN = 4'hC;     // 1100xxxx
  localparam logic [7:0] OP_OFFSET = 8'hD3;
  localparam logic [7:0] OP_PRECHG = 8'hD9;
  localparam logic [7:0] OP_PINCFG = 8'hDA;
  localparam logic [7:0] OP_RESVD = 8'hE2;
  localparam logic [7:0] OP_NOP = 8'hE3;
  // power-on defaults
  localparam logic [7:0] RST_CONTRAST = 8'h80;
  localparam logic [5:0] RST_MUX = 6'h3F;    // register value 63 means 64 rows
  localparam logic [5:0] RST_OFFSET = 6'h00;
  localparam logic [3:0] RST_PRECHG = 4'h2;
  localparam logic RST_ALT_PINS = 1'b1;
  localparam logic [5:0] MUX_MIN = 6'h0F;    // 16 rows
  // parameter-wait states, Gray along the path idle->wait
  typedef enum logic [1:0] {ODC_IDLE = 2'b00, ODC_WAIT = 2'b01} odc_state_e;
  typedef enum logic [2:0] {
    ODC_P_NONE = 3'h0, ODC_P_CONTRAST = 3'h1, ODC_P_MUX = 3'h2,
    ODC_P_OFFSET = 3'h3, ODC_P_PRECHG = 3'h4, ODC_P_PINCFG = 3'h5
  } odc_param_e;
endpackage

// ===== rtl/odc_byte_if.sv
`timescale 1ns/100ps
// carries one byte from the bus slave to the decoder
interface odc_byte_if;
  logic valid;    // one-cycle pulse
  logic cmd_sel;  // low means command byte
  logic [7:0] data;
  modport src (output valid, output cmd_sel, output data);
  modport dst (input valid, input cmd_sel, input data);
endinterface

// ===== rtl/odc_axil_slave.sv
`timescale 1ns/100ps
// axi4-lite slave: byte push on write, readback of settings
module odc_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic [31:0] rd_ctrl,
  input wire logic [31:0] rd_mode,
  input wire logic [31:0] rd_stat,
  odc_byte_if.src byte_out
);
  typedef struct packed {
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic push;
    logic push_sel;
    logic [7:0] push_data;
  } odc_axs_s;
  odc_axs_s st, next_st;

  assign s_awready = !st.aw_have && !st.bvalid;
  assign s_wready = !st.w_have && !st.bvalid;
  assign s_arready = !st.rvalid;
  assign s_bvalid = st.bvalid;
  assign s_bresp = st.bresp;
  assign s_rvalid = st.rvalid;
  assign s_rresp = st.rresp;
  assign s_rdata = st.rdata;
  assign byte_out.valid = st.push;
  assign byte_out.cmd_sel = st.push_sel;
  assign byte_out.data = st.push_data;

  // accept address and data in either order, answer after both
  always_comb begin
    next_st = st;
    next_st.push = 1'b0;
    if (s_awvalid && s_awready) begin
      next_st.aw_have = 1'b1;
      next_st.awaddr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      next_st.w_have = 1'b1;
      next_st.wdata = s_wdata;
      next_st.wstrb = s_wstrb;
    end
    if (st.aw_have && st.w_have) begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      if ({st.awaddr[7:2], 2'b00} == odc_pkg::REG_BYTE) begin
        next_st.bresp = 2'h0;
        // byte lanes 0 and 1 must both be written
        if (st.wstrb[1:0] == 2'h3) begin
          next_st.push = 1'b1;
          next_st.push_sel = st.wdata[odc_pkg::DC_BIT];
          next_st.push_data = st.wdata[7:0];
        end
      end else begin
        next_st.bresp = 2'h2;  // read-only or unmapped
      end
    end
    if (st.bvalid && s_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = 2'h0;
      case ({s_araddr[7:2], 2'b00})
        odc_pkg::REG_BYTE: next_st.rdata = 32'h0000_0000;
        odc_pkg::REG_CTRL: next_st.rdata = rd_ctrl;
        odc_pkg::REG_MODE: next_st.rdata = rd_mode;
        odc_pkg::REG_STAT: next_st.rdata = rd_stat;
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = 2'h2;
        end
      endcase
    end else if (st.rvalid && s_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ===== rtl/odc_param_decoder.sv
`timescale 1ns/100ps
// What this block does
// - 0x81 then contrast byte, default 80h
// - contrast drive rises with value while panel is on, zero while off
// - 1010010x forces all pixels on
// - 1010011x inverts pixel polarity
// - 0xA8 then six-bit mux ratio, 16-64
// - 1010111x switches panel, off at reset
// - 1011xxxx loads page address 0-7
// - 1100 bit3 reverses row scan direction
// - 0xD3 then six-bit vertical offset, reset 0
// - 0xD9 then pre-charge in upper nibble
// - 0xDA parameter bit4 picks row-pin layout
// - 0xE3 is no-operation
// - reset loads all documented defaults
module odc_param_decoder (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [7:0] contrast_level,
  output logic [7:0] drive_level,
  output logic entire_on,
  output logic inverse,
  output logic [5:0] mux_ratio,
  output logic panel_on,
  output logic [3:0] page_addr,
  output logic scan_reversed,
  output logic [5:0] row_offset,
  output logic [3:0] precharge_ticks,
  output logic alt_row_pins,
  output logic [7:0] display_data,
  output logic display_data_valid
);
  // bytes arrive over the register bus: select low marks a command,
  // select high marks display data, which passes straight out.
  // a two-byte opcode parks the decoder in the wait state, so the next
  // command byte is read as its parameter whatever its value.
  // all decoder state
  typedef struct packed {
    odc_pkg::odc_state_e state;   // waiting for parameter or not
    odc_pkg::odc_param_e pend;    // which parameter is due
    logic [7:0] contrast;
    logic entire;
    logic inv;
    logic [5:0] mux;
    logic panel;
    logic [3:0] page;
    logic scan_rev;
    logic [5:0] offset;
    logic [3:0] prechg;
    logic alt_pins;
    logic [7:0] ddata;
    logic dvalid;
    logic [7:0] drive;            // panel drive level, zero while off
    logic [7:0] cmd_count;        // commands taken, wraps
    logic [7:0] last_cmd;
    logic bad_param;              // sticky: parameter out of range
  } odc_dec_s;
  odc_dec_s st, next_st;
  odc_byte_if bif ();
  logic [31:0] rd_ctrl;
  logic [31:0] rd_mode;
  logic [31:0] rd_stat;
  logic cmd_in;        // command byte strobe
  logic data_in;       // display data byte strobe
  logic param_due;     // a parameter byte is expected next
  logic [7:0] b;       // byte on the carrier

  // register bus slave feeding bytes in
  odc_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .rd_ctrl(rd_ctrl),
    .rd_mode(rd_mode),
    .rd_stat(rd_stat),
    .byte_out(bif.src)
  );

  // readback words, one field per line so the bit map reads off directly
  // control word: offset, page and contrast
  assign rd_ctrl = {
    2'h0,
    st.offset,     // [29:24]
    4'h0,
    st.page,       // [19:16]
    8'h00,
    st.contrast    // [7:0]
  };
  // mode word: flags, mux ratio and pre-charge length
  assign rd_mode = {
    17'h0,
    st.prechg,     // [14:11]
    st.mux,        // [10:5]
    st.alt_pins,   // [4]
    st.scan_rev,   // [3]
    st.panel,      // [2]
    st.inv,        // [1]
    st.entire      // [0]
  };
  // status word: sticky range error, wait flag, last command, command count
  assign param_due = st.state == odc_pkg::ODC_WAIT;
  assign rd_stat = {
    14'h0,
    st.bad_param,  // [17]
    param_due,     // [16]
    st.last_cmd,   // [15:8]
    st.cmd_count   // [7:0]
  };

  // command byte when select is low
  assign cmd_in = bif.valid && !bif.cmd_sel;
  // data byte when select is high
  assign data_in = bif.valid && bif.cmd_sel;
  assign b = bif.data;

  // outputs straight from state flops
  // every setting output is a flop, so the panel side never sees a glitch
  assign contrast_level = st.contrast;
  // drive level has its own flop so a panel switch cannot glitch it
  assign drive_level = st.drive;
  assign entire_on = st.entire;
  assign inverse = st.inv;
  assign mux_ratio = st.mux;
  assign panel_on = st.panel;
  assign page_addr = st.page;
  assign scan_reversed = st.scan_rev;
  assign row_offset = st.offset;
  assign precharge_ticks = st.prechg;
  assign alt_row_pins = st.alt_pins;
  assign display_data = st.ddata;
  assign display_data_valid = st.dvalid;

  // byte decode
  always_comb begin
    next_st = st;
    next_st.dvalid = 1'b0;
    if (data_in) begin
      // display data passes straight on
      next_st.ddata = b;
      next_st.dvalid = 1'b1;
    end else if (cmd_in) begin
      // every command byte is counted and remembered for the status word
      next_st.cmd_count = st.cmd_count + 8'h01;
      next_st.last_cmd = b;
      if (st.state == odc_pkg::ODC_WAIT) begin
        // parameter byte, never a new opcode
        next_st.state = odc_pkg::ODC_IDLE;
        next_st.pend = odc_pkg::ODC_P_NONE;
        case (st.pend)
          odc_pkg::ODC_P_CONTRAST: next_st.contrast = b;
          odc_pkg::ODC_P_MUX: begin
            // ratio is held as rows minus one
            if (b[5:0] >= odc_pkg::MUX_MIN) begin
              next_st.mux = b[5:0];
            end else begin
              // fewer than sixteen rows: keep the old ratio, flag it
              next_st.bad_param = 1'b1;
            end
          end
          odc_pkg::ODC_P_OFFSET: next_st.offset = b[5:0];
          odc_pkg::ODC_P_PRECHG: next_st.prechg = b[7:4];
          odc_pkg::ODC_P_PINCFG: next_st.alt_pins = b[4];
          default: next_st.bad_param = st.bad_param;
        endcase
      end else begin
        // opcode byte: a two-byte opcode arms the wait state
        case (b)
          odc_pkg::OP_CONTRAST: begin
            next_st.state = odc_pkg::ODC_WAIT;
            next_st.pend = odc_pkg::ODC_P_CONTRAST;
          end
          odc_pkg::OP_MUX: begin
            next_st.state = odc_pkg::ODC_WAIT;
            next_st.pend = odc_pkg::ODC_P_MUX;
          end
          odc_pkg::OP_OFFSET: begin
            next_st.state = odc_pkg::ODC_WAIT;
            next_st.pend = odc_pkg::ODC_P_OFFSET;
          end
          odc_pkg::OP_PRECHG: begin
            next_st.state = odc_pkg::ODC_WAIT;
            next_st.pend = odc_pkg::ODC_P_PRECHG;
          end
          odc_pkg::OP_PINCFG: begin
            next_st.state = odc_pkg::ODC_WAIT;
            next_st.pend = odc_pkg::ODC_P_PINCFG;
          end
          // reserved and no-op codes touch no setting and stay idle
          odc_pkg::OP_RESVD: next_st.state = odc_pkg::ODC_IDLE;
          odc_pkg::OP_NOP: next_st.state = odc_pkg::ODC_IDLE;
          default: begin
            // single-byte opcodes
            if (b[7:1] == odc_pkg::OP_ENTIRE) begin
              next_st.entire = b[0];
            end else if (b[7:1] == odc_pkg::OP_INVERSE) begin
              next_st.inv = b[0];
            end else if (b[7:1] == odc_pkg::OP_PANEL) begin
              next_st.panel = b[0];
            end else if (b[7:4] == odc_pkg::OP_PAGE) begin
              next_st.page = {1'b0, b[2:0]};
            end else if (b[7:4] == odc_pkg::OP_SCAN) begin
              next_st.scan_rev = b[3];
            end
          end
        endcase
      end
    end
    // drive follows contrast only while the panel is lit
    next_st.drive = next_st.panel ? next_st.contrast : 8'h00;
  end

  // state register, defaults on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.state <= odc_pkg::ODC_IDLE;
      st.pend <= odc_pkg::ODC_P_NONE;
      st.contrast <= odc_pkg::RST_CONTRAST;
      st.mux <= odc_pkg::RST_MUX;
      st.offset <= odc_pkg::RST_OFFSET;
      st.prechg <= odc_pkg::RST_PRECHG;
      st.alt_pins <= odc_pkg::RST_ALT_PINS;
      // page, flags, drive, data and status fields stay at zero
    end else begin
      st <= next_st;
    end
  end

  // checks on parameter loads
  AST_CONTRAST: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && param_due && st.pend == odc_pkg::ODC_P_CONTRAST
    |=> contrast_level == $past(b)) else $error("contrast not loaded");
  AST_MUX_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && param_due && st.pend == odc_pkg::ODC_P_MUX
    |=> mux_ratio == ($past(b[5:0]) >= odc_pkg::MUX_MIN ? $past(b[5:0]) : $past(mux_ratio)))
    else $error("mux ratio not loaded");
  AST_OFFSET: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && param_due && st.pend == odc_pkg::ODC_P_OFFSET |=> row_offset == $past(b[5:0]))
    else $error("offset not loaded");
  AST_PRECHG: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && param_due && st.pend == odc_pkg::ODC_P_PRECHG |=> precharge_ticks == $past(b[7:4]))
    else $error("pre-charge not loaded");
  AST_PINCFG: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && param_due && st.pend == odc_pkg::ODC_P_PINCFG |=> alt_row_pins == $past(b[4]))
    else $error("pin layout not loaded");
  AST_ARM: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && !param_due && (b == odc_pkg::OP_CONTRAST || b == odc_pkg::OP_MUX || b == odc_pkg::OP_OFFSET
      || b == odc_pkg::OP_PRECHG || b == odc_pkg::OP_PINCFG) |=> param_due)
    else $error("two-byte opcode did not wait");

  // checks on single-byte opcodes, drive and no-op
  AST_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)
    panel_on && $stable(panel_on) && contrast_level > $past(contrast_level) |-> drive_level > $past(drive_level))
    else $error("drive not monotonic");
  AST_ENTIRE: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && st.state == odc_pkg::ODC_IDLE && b[7:1] == odc_pkg::OP_ENTIRE |=> entire_on == $past(b[0]))
    else $error("entire-on wrong");
  AST_INVERSE: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && st.state == odc_pkg::ODC_IDLE && b[7:1] == odc_pkg::OP_INVERSE |=> inverse == $past(b[0]))
    else $error("inverse wrong");
  AST_PANEL: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && st.state == odc_pkg::ODC_IDLE && b[7:1] == odc_pkg::OP_PANEL |=> panel_on == $past(b[0]))
    else $error("panel wrong");
  AST_PAGE: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && st.state == odc_pkg::ODC_IDLE && b[7:4] == odc_pkg::OP_PAGE |=> page_addr == {1'b0, $past(b[2:0])})
    else $error("page wrong");
  AST_SCAN: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && st.state == odc_pkg::ODC_IDLE && b[7:4] == odc_pkg::OP_SCAN |=> scan_reversed == $past(b[3]))
    else $error("scan wrong");
  AST_MUX_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
    mux_ratio >= odc_pkg::MUX_MIN) else $error("mux out of range");
  AST_NOP: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && st.state == odc_pkg::ODC_IDLE && (b == odc_pkg::OP_NOP || b == odc_pkg::OP_RESVD)
    |=> $stable(rd_ctrl) && $stable(rd_mode)) else $error("nop changed setting");
  AST_PARAM: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && st.state == odc_pkg::ODC_WAIT |=> st.state == odc_pkg::ODC_IDLE && $stable(panel_on) && $stable(page_addr))
    else $error("parameter taken as opcode");

  // checks on reset, data pass-through and sticky state
  AST_RESET: assert property (@(posedge aclk)
    !aresetn |=> contrast_level == odc_pkg::RST_CONTRAST && mux_ratio == odc_pkg::RST_MUX
      && alt_row_pins == odc_pkg::RST_ALT_PINS && !panel_on && precharge_ticks == odc_pkg::RST_PRECHG)
    else $error("defaults not loaded");
  AST_RESET_REST: assert property (@(posedge aclk)
    !aresetn |=> !param_due && !entire_on && !inverse && !scan_reversed && row_offset == odc_pkg::RST_OFFSET)
    else $error("cleared settings not loaded");
  AST_DATA: assert property (@(posedge aclk) disable iff (!aresetn)
    data_in |=> display_data_valid && display_data == $past(b) && $stable(param_due) && $stable(st.pend)
      && $stable(rd_ctrl) && $stable(rd_mode))
    else $error("data byte disturbed decoder");
  AST_DRIVE_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    !panel_on |-> drive_level == 8'h00)
    else $error("drive while panel off");
  AST_BAD_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
    st.bad_param |=> st.bad_param)
    else $error("range flag lost");
  AST_RESVD: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && !param_due && b == odc_pkg::OP_RESVD |=> !param_due && $stable(rd_ctrl) && $stable(rd_mode))
    else $error("reserved code changed state");

  // scenario covers
  COV_CONTRAST: cover property (@(posedge aclk) disable iff (!aresetn)
    st.pend == odc_pkg::ODC_P_CONTRAST ##1 st.state == odc_pkg::ODC_IDLE);
  COV_PANEL_ON: cover property (@(posedge aclk) disable iff (!aresetn) $rose(panel_on));
  COV_DATA: cover property (@(posedge aclk) disable iff (!aresetn) display_data_valid);
  COV_BAD: cover property (@(posedge aclk) disable iff (!aresetn) $rose(st.bad_param));
  COV_RESVD: cover property (@(posedge aclk) disable iff (!aresetn)
    cmd_in && !param_due && b == odc_pkg::OP_RESVD);
endmodule

// ===== dv/odc_host_model.sv
`timescale 1ns/100ps
// host side: axi4-lite master that pushes command and data bytes
module odc_host_model (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  logic hung; // set once the slave fails to answer in time
  // idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    hung = 1'b0;
  end
  // one write; readiness is sampled mid-cycle so the taking edge is never raced
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, go;
    int n;
    go = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && go; n++) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      go = !bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (!go) bready <= 1'b0;
    end
    hung = hung | go;
  endtask
  // one read; data and response taken at the edge that sees rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, go;
    int n;
    go = 1'b1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && go; n++) begin
      @(negedge aclk);
      ta = arready;
      go = !rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (!go) rready <= 1'b0;
    end
    hung = hung | go;
  endtask
  // command byte: select bit held low
  task automatic cmd(input logic [7:0] b);
    logic [1:0] r;
    wr(odc_pkg::REG_BYTE, {23'h0, 1'b0, b}, r);
  endtask
  // display data byte: select bit high
  task automatic dat(input logic [7:0] b);
    logic [1:0] r;
    wr(odc_pkg::REG_BYTE, {23'h0, 1'b1, b}, r);
  endtask
endmodule

// ===== dv/oled_display_command_decoder_bench.sv
`timescale 1ns/100ps
// drives command sequences through the host model and checks the settings
module oled_display_command_decoder_bench;
  logic aclk, aresetn;
  logic [7:0] awaddr, araddr, con, drv;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0] wstrb, pg, pre;
  logic [1:0] bresp, rresp, rr;
  logic ent, inv, pan, scn, alt;
  logic [5:0] mux, ofs;
  // expected settings
  logic [7:0] e_con;
  logic e_ent, e_inv, e_pan, e_scn, e_alt;
  logic [5:0] e_mux, e_ofs;
  logic [3:0] e_pg, e_pre;
  int miscompares, n_checks;
  logic [7:0] dd;  // display data output
  logic ddv;       // display data strobe
  int n_dv = 0;    // data strobes seen

  odc_param_decoder dut_u (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .contrast_level(con), .drive_level(drv), .entire_on(ent), .inverse(inv), .mux_ratio(mux),
    .panel_on(pan), .page_addr(pg), .scan_reversed(scn), .row_offset(ofs), .precharge_ticks(pre),
    .alt_row_pins(alt), .display_data(dd), .display_data_valid(ddv));
  odc_host_model host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // 40 MHz clock
  always #12.5 aclk = ~aclk;

  // count one-cycle data strobes from the decoder
  always @(posedge aclk) begin
    if (ddv === 1'b1) begin
      n_dv <= n_dv + 1;
    end
  end

  // single comparison point
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // closing report
  task automatic results();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // stop early when the bus hangs
  task automatic alive();
    if (host_u.hung) begin
      miscompares++;
      results();
    end
  endtask
  // power-on values of every setting
  task automatic dflt();
    e_con = 8'h80;
    {e_ent, e_inv, e_pan, e_scn, e_pg} = '0;
    e_mux = 6'h3F;
    e_ofs = 6'h00;
    e_pre = 4'h2;
    e_alt = 1'b1;
  endtask
  // compare all setting outputs; drive follows contrast only while the panel is on
  task automatic cmp();
    @(negedge aclk);
    chk({con, drv, ent, inv, mux, pan, pg, scn, ofs, pre, alt},
        {e_con, (e_pan ? e_con : 8'h00), e_ent, e_inv, e_mux, e_pan, e_pg, e_scn, e_ofs, e_pre, e_alt});
  endtask
  // one command byte
  task automatic c1(input logic [7:0] b);
    host_u.cmd(b);
    alive();
  endtask
  // opcode and its parameter
  task automatic c2(input logic [7:0] op, input logic [7:0] prm);
    c1(op);
    c1(prm);
  endtask

  // main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    miscompares = 0;
    n_checks = 0;
    dflt();
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    cmp();
    host_u.rd(odc_pkg::REG_MODE, rdv, rr);
    alive();
    chk({rr, rdv}, {2'h0, 32'h0000_17F0});
    host_u.rd(8'h10, rdv, rr);
    alive();
    chk({rr, rdv}, {2'h2, 32'h0});
    host_u.wr(8'h10, 32'h0000_0081, rr);
    alive();
    chk(rr, 2'h2);
    $display("test bus done");
    // contrast with a data byte slipped in before its parameter
    c1(odc_pkg::OP_CONTRAST);
    host_u.dat(8'h5A);
    alive();
    c1(8'h00);
    e_con = 8'h00;
    cmp();
    chk({dd, n_dv}, {8'h5A, 32'h0000_0001});
    c1({odc_pkg::OP_PANEL, 1'b1});
    e_pan = 1'b1;
    cmp();
    c2(odc_pkg::OP_CONTRAST, 8'h01);
    e_con = 8'h01;
    cmp();
    c2(odc_pkg::OP_CONTRAST, 8'hFF);
    e_con = 8'hFF;
    cmp();
    c2(odc_pkg::OP_CONTRAST, odc_pkg::OP_MUX);
    e_con = odc_pkg::OP_MUX;
    cmp();
    $display("test contrast done");
    // single-byte mode flags, set then cleared one at a time
    for (int b = 1; b >= 0; b--) begin
      c1({odc_pkg::OP_ENTIRE, b[0]});
      e_ent = b[0];
      cmp();
      c1({odc_pkg::OP_INVERSE, b[0]});
      e_inv = b[0];
      cmp();
      c1({odc_pkg::OP_SCAN, b[0], 3'b101});
      e_scn = b[0];
      cmp();
    end
    c1({odc_pkg::OP_PANEL, 1'b0});
    e_pan = 1'b0;
    cmp();
    $display("test flags done");
    // mux boundary, below-minimum value leaves the setting alone
    c2(odc_pkg::OP_MUX, 8'h0F);
    e_mux = 6'h0F;
    cmp();
    c2(odc_pkg::OP_MUX, 8'h0E);
    cmp();
    host_u.rd(odc_pkg::REG_STAT, rdv, rr);
    alive();
    chk({rr, rdv[17:8]}, {2'h0, 2'h2, 8'h0E});
    c1({odc_pkg::OP_PAGE, 4'h7});
    e_pg = 4'h7;
    cmp();
    c2(odc_pkg::OP_OFFSET, 8'h3F);
    e_ofs = 6'h3F;
    cmp();
    c2(odc_pkg::OP_PRECHG, 8'hF2);
    e_pre = 4'hF;
    cmp();
    c2(odc_pkg::OP_PRECHG, 8'h12);
    e_pre = 4'h1;
    cmp();
    c2(odc_pkg::OP_PINCFG, 8'h02);
    e_alt = 1'b0;
    cmp();
    $display("test params done");
    // no-operation and reserved codes change nothing, next byte is an opcode
    c1(odc_pkg::OP_NOP);
    cmp();
    c1(odc_pkg::OP_RESVD);
    c1({odc_pkg::OP_PAGE, 4'h5});
    e_pg = 4'h5;
    cmp();
    host_u.rd(odc_pkg::REG_CTRL, rdv, rr);
    alive();
    chk({rr, rdv}, {2'h0, 2'h0, e_ofs, 4'h0, e_pg, 8'h00, e_con});
    // second reset in mid-run, with a parameter still due, restores every default
    c1(odc_pkg::OP_CONTRAST);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    dflt();
    cmp();
    c1({odc_pkg::OP_PAGE, 4'h3});
    e_pg = 4'h3;
    cmp();
    $display("test reset done");
    results();
  end
endmodule
